// [rtl/tlelm_pkg.sv]
// package for the true little-endian lane mapper: request and beat carriers, constants
// assumes one processor-side clock; beats go to a pci-side engine that can stall
package tlelm_pkg;

    localparam int LANES_PB  = 8;
    localparam int LANES_PCI = 4;
    localparam int ADDR_W    = 32;

    // transfer size codes in bytes, 0 stands for a full doubleword
    localparam logic [2:0] SIZE_DOUBLE = 3'h0;
    localparam logic [2:0] SIZE_BYTE   = 3'h1;
    localparam logic [2:0] SIZE_TWO    = 3'h2;
    localparam logic [2:0] SIZE_WORD   = 3'h4;

    // endian-mode codes
    localparam logic [1:0] END_TRUE_LE = 2'h3;

    // bit of the pci address that picks the upper doubleword
    localparam int A2_POS = 2;

    typedef struct packed {
        logic [ADDR_W-1:0]        addr;
        logic [2:0]               size;
        logic                     write;
        logic [LANES_PB*8-1:0]    data;
    } tlelm_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0]        addr;
        logic [LANES_PCI-1:0]     byte_en;
        logic                     write;
        logic [LANES_PCI*8-1:0]   data;
        logic                     last;
    } tlelm_beat_s;

    typedef struct packed {
        logic [LANES_PCI*8-1:0]   data;
        logic                     last;
    } tlelm_rbeat_s;

endpackage : tlelm_pkg

// [rtl/tlelm_lane_mapper.sv]
// true little-endian lane mapper: splits one processor access into one or two pci doublewords
// assumes processor-side request and pci-side beat engine share the processor bus clock
// Summary of operation
// (RULE1) bytes keep relative significance; only byte addressing changes
// (RULE2) address bits pass to pci without swap or modification
// (RULE3) most significant processor lane goes to most significant pci lane
// (RULE4) msb is lowest address on processor side, highest on pci side
// (RULE5) lanes 0-3 to a1:0 11..00 with a2 low; 4-7 with a2 high
// (RULE6) software must not enable four-byte reads with true little-endian
// (RULE7) memory-versus-io select must be zero with true little-endian code
// (RULE8) four-byte reads stay allowed under all other endian modes
// (RULE9) split transfers send the a2-low doubleword before the a2-high one
// (RULE10) only tabled size and start-address pairs are accepted
`timescale 1ns/1ps
module tlelm_lane_mapper (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic [1:0]             endian_mode,
    input  wire logic                   four_byte_read_en,
    input  wire logic                   mem_io_sel,
    input  wire logic                   req_valid,
    input  wire tlelm_pkg::tlelm_req_s  req,
    output logic                        req_ready,
    output logic                        req_error,
    output logic                        cfg_conflict,
    output logic                        beat_valid,
    output tlelm_pkg::tlelm_beat_s      beat,
    input  wire logic                   beat_ready,
    input  wire logic                   rbeat_valid,
    input  wire tlelm_pkg::tlelm_rbeat_s rbeat,
    output logic                        rdata_valid,
    output logic [63:0]                 rdata
);
    typedef enum logic [2:0] {
        TLELM_IDLE  = 3'b001,
        TLELM_SEND  = 3'b010,
        TLELM_READ  = 3'b100
    } tlelm_state_e;

    tlelm_state_e  state_r;
    tlelm_state_e  state_nxt;

    // (RULE10) legal size/start pairs of the lane map
    function automatic logic legal_pair(input logic [2:0] size, input logic [2:0] sa);
        case (size)
            3'h1:    legal_pair = 1'b1;
            3'h2:    legal_pair = (sa[0] == 1'b0);
            3'h3:    legal_pair = (sa[1] == 1'b0);
            3'h4:    legal_pair = (sa[1:0] == 2'h0);
            3'h5:    legal_pair = (sa == 3'h0) || (sa == 3'h3);
            3'h6:    legal_pair = (sa == 3'h0) || (sa == 3'h2);
            3'h7:    legal_pair = (sa == 3'h0) || (sa == 3'h1);
            default: legal_pair = (sa == 3'h0);
        endcase
    endfunction : legal_pair

    // processor lanes touched: size bytes from start address, size 0 means eight
    function automatic logic [7:0] lane_mask(input logic [2:0] size, input logic [2:0] sa);
        logic [15:0] m;
        m = 16'h0;
        m = (size == 3'h0) ? 16'h00ff : ((16'h0001 << size) - 16'h0001);
        m = m << sa;
        lane_mask = m[7:0];
    endfunction : lane_mask

    logic                   is_true_le;
    logic [2:0]             start_addr;
    logic [7:0]             pb_mask;
    logic                   need_lo;
    logic                   need_hi;
    logic                   legal;
    assign is_true_le = (endian_mode == tlelm_pkg::END_TRUE_LE);
    assign start_addr = req.addr[2:0];
    assign pb_mask    = lane_mask(req.size, start_addr);
    assign need_lo    = |pb_mask[3:0];
    assign need_hi    = |pb_mask[7:4];
    assign legal      = legal_pair(req.size, start_addr);

    // processor lane i (i=0 most significant) sits in bits [63-8i -: 8] of req.data
    // pci lane with a[1:0]=k sits in bits [8k+7:8k]; lane j of a half goes to k = 3-j
    logic [31:0]            pci_lo;
    logic [31:0]            pci_hi;
    logic [3:0]             be_lo;
    logic [3:0]             be_hi;
    genvar                  g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign pci_lo[(3-g)*8 +: 8] = req.data[63-8*g -: 8];     // RULE3
            assign pci_hi[(3-g)*8 +: 8] = req.data[31-8*g -: 8];     // RULE5
            assign be_lo[3-g]           = pb_mask[g];                // RULE5
            assign be_hi[3-g]           = pb_mask[g+4];              // RULE4
        end
    endgenerate

    logic [31:0]            base_addr;
    assign base_addr = {req.addr[31:3], 3'h0};                      // RULE2

    // latched request
    tlelm_pkg::tlelm_req_s  hold_r;
    logic [31:0]            lo_data_r;
    logic [31:0]            hi_data_r;
    logic [3:0]             lo_be_r;
    logic [3:0]             hi_be_r;
    logic                   lo_pend_r;
    logic                   hi_pend_r;
    logic [31:0]            base_r;

    logic                   accept;
    logic                   reject;
    logic                   beat_done;
    logic                   send_hi;
    logic                   read_done;
    assign accept    = (state_r == TLELM_IDLE) && req_valid && is_true_le && legal;
    assign reject    = (state_r == TLELM_IDLE) && req_valid && !(is_true_le && legal);
    assign beat_done = beat_valid && beat_ready;
    assign send_hi   = !lo_pend_r;                                   // RULE9
    assign read_done = (state_r == TLELM_READ) && rbeat_valid && rbeat.last;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TLELM_IDLE: if (accept) state_nxt = TLELM_SEND;
            TLELM_SEND: if (beat_done && beat.last) begin
                state_nxt = hold_r.write ? TLELM_IDLE : TLELM_READ;
            end
            TLELM_READ: if (read_done) state_nxt = TLELM_IDLE;
            default:    state_nxt = TLELM_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= TLELM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hold_r    <= '0;
            lo_data_r <= 32'h0;
            hi_data_r <= 32'h0;
            lo_be_r   <= 4'h0;
            hi_be_r   <= 4'h0;
            lo_pend_r <= 1'b0;
            hi_pend_r <= 1'b0;
            base_r    <= 32'h0;
        end else if (accept) begin
            hold_r    <= req;
            lo_data_r <= pci_lo;                                     // RULE1
            hi_data_r <= pci_hi;
            lo_be_r   <= be_lo;
            hi_be_r   <= be_hi;
            lo_pend_r <= need_lo;
            hi_pend_r <= need_hi;
            base_r    <= base_addr;
        end else if (beat_done) begin
            if (lo_pend_r) lo_pend_r <= 1'b0;                        // RULE9
            else           hi_pend_r <= 1'b0;
        end
    end

    // beat output registers, reloaded from pending halves
    tlelm_pkg::tlelm_beat_s beat_nxt;
    logic                   bvalid_nxt;
    logic                   lo_next;
    logic                   hi_next;
    assign lo_next = accept ? need_lo : (beat_done ? 1'b0 : lo_pend_r);
    assign hi_next = accept ? need_hi : (beat_done && send_hi ? 1'b0 : hi_pend_r);

    always_comb begin
        beat_nxt         = '0;
        beat_nxt.write   = accept ? req.write : hold_r.write;
        bvalid_nxt       = (state_nxt == TLELM_SEND) && (lo_next || hi_next);
        if (lo_next) begin
            beat_nxt.addr    = accept ? base_addr : base_r;          // RULE5
            beat_nxt.byte_en = accept ? be_lo : lo_be_r;
            beat_nxt.data    = accept ? pci_lo : lo_data_r;
            beat_nxt.last    = !hi_next;
        end else begin
            beat_nxt.addr    = (accept ? base_addr : base_r) | 32'h4; // RULE5
            beat_nxt.byte_en = accept ? be_hi : hi_be_r;
            beat_nxt.data    = accept ? pci_hi : hi_data_r;
            beat_nxt.last    = 1'b1;
        end
    end

    // read return: reassemble in the same lane order, low doubleword first
    logic                   rd_hi_r;
    logic [63:0]            rasm_r;
    logic [63:0]            rlane;
    logic                   rd_is_hi;
    assign rd_is_hi = rd_hi_r || !(|lo_be_r);
    generate
        for (g = 0; g < 4; g++) begin : g_rlane
            assign rlane[63-8*g -: 8] = rd_is_hi ? rasm_r[63-8*g -: 8] : rbeat.data[(3-g)*8 +: 8];
            assign rlane[31-8*g -: 8] = rd_is_hi ? rbeat.data[(3-g)*8 +: 8] : rasm_r[31-8*g -: 8];
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            beat_valid   <= 1'b0;
            beat         <= '0;
            req_ready    <= 1'b0;
            req_error    <= 1'b0;
            cfg_conflict <= 1'b0;
            rdata_valid  <= 1'b0;
            rdata        <= 64'h0;
            rasm_r       <= 64'h0;
            rd_hi_r      <= 1'b0;
        end else begin
            beat_valid   <= bvalid_nxt;
            beat         <= beat_nxt;
            req_ready    <= accept || reject;
            req_error    <= reject;                                  // RULE10
            // only true little-endian clashes with four-byte reads or io select
            cfg_conflict <= is_true_le && (four_byte_read_en || mem_io_sel); // RULE6 RULE7 RULE8
            rdata_valid  <= read_done;
            if (accept) begin
                rd_hi_r <= 1'b0;
            // first half of a split read returns while the second beat is still in flight
            end else if ((state_r != TLELM_IDLE) && rbeat_valid) begin
                rasm_r  <= rlane;
                rd_hi_r <= 1'b1;
                if (rbeat.last) rdata <= rlane;
            end
        end
    end

endmodule : tlelm_lane_mapper

// [sim/tlelm_lane_mapper_asserts.sv]
// port assertions for the true little-endian lane mapper
// assumes one clock domain; bound to the mapper from the bench top file
`timescale 1ns/1ps
module tlelm_lane_mapper_asserts (
    input wire logic                     clock,
    input wire logic                     reset_n,
    input wire logic [1:0]               endian_mode,
    input wire logic                     four_byte_read_en,
    input wire logic                     mem_io_sel,
    input wire logic                     req_valid,
    input wire logic                     req_ready,
    input wire logic                     req_error,
    input wire logic                     cfg_conflict,
    input wire logic                     beat_valid,
    input wire tlelm_pkg::tlelm_beat_s   beat,
    input wire logic                     beat_ready,
    input wire logic                     rbeat_valid,
    input wire tlelm_pkg::tlelm_rbeat_s  rbeat,
    input wire logic                     rdata_valid
);
    wire conflict_c = endian_mode == tlelm_pkg::END_TRUE_LE && (four_byte_read_en || mem_io_sel);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_ready_pulse: assert property (req_ready |=> !req_ready)
        else $error("request ready longer than one cycle");
    a_error_pair: assert property (req_error |-> req_ready)
        else $error("refusal without ready");
    a_ready_cause: assert property (req_ready |-> $past(req_valid))
        else $error("ready without a request");
    a_accept_mode: assert property (req_ready && !req_error |->
        $past(endian_mode) == tlelm_pkg::END_TRUE_LE)
        else $error("access accepted outside true little-endian mode");
    a_beat_follows: assert property (req_ready && !req_error |-> beat_valid)
        else $error("accepted access without a beat");
    a_beat_hold: assert property (beat_valid && !beat_ready |=> beat_valid && $stable(beat))
        else $error("beat changed before it was taken");
    a_beat_lanes: assert property (beat_valid |-> beat.addr[1:0] == 2'h0 && beat.byte_en != 4'h0)
        else $error("beat with bad low address or no lanes");
    a_low_first: assert property (beat_valid && !beat.last |-> !beat.addr[tlelm_pkg::A2_POS])
        else $error("upper doubleword sent before the lower one");
    a_cfg_flag: assert property ($past(reset_n) |-> cfg_conflict == $past(conflict_c))
        else $error("configuration conflict flag wrong");
    a_rdata_follow: assert property (rbeat_valid && rbeat.last |=> rdata_valid)
        else $error("read data not returned after last beat");
    c_split: cover property (beat_valid && beat_ready && beat.last && beat.addr[2]);
    c_refused: cover property (req_error);
    c_read: cover property (rdata_valid);
endmodule : tlelm_lane_mapper_asserts

// [sim/tlelm_pci_model.sv]
// pci-side beat sink and read responder facing the lane mapper
// assumes the shared processor clock; slow adds wait cycles before ready
`timescale 1ns/1ps
module tlelm_pci_model (
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    input  wire logic                    slow,
    input  wire logic                    beat_valid,
    input  wire tlelm_pkg::tlelm_beat_s  beat,
    output logic                         beat_ready,
    output logic                         rbeat_valid,
    output tlelm_pkg::tlelm_rbeat_s      rbeat
);
    logic [1:0] wait_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            beat_ready <= 1'b0;
            rbeat_valid <= 1'b0;
            wait_r <= 2'h0;
            rbeat <= '0;
        end else begin
            rbeat_valid <= 1'b0;
            // idle read lines toggle so a stale value never passes for data
            rbeat.data <= ~rbeat.data;
            if (beat_valid && beat_ready) begin
                beat_ready <= 1'b0;
                wait_r <= 2'h0;
                if (!beat.write) begin
                    rbeat_valid <= 1'b1;
                    rbeat <= '{~beat.addr, beat.last};
                end
            end else if (beat_valid) begin
                wait_r <= wait_r + 2'h1;
                beat_ready <= !slow || wait_r == 2'h2;
            end
        end
    end
endmodule : tlelm_pci_model

// [sim/tlelm_lane_mapper_tb_top.sv]
// self-checking bench for the true little-endian lane mapper
// assumes the pci model answers beats; inputs change on the falling edge
`timescale 1ns/1ps
module tlelm_lane_mapper_tb_top;
    logic                    clock = 1'b0;
    logic                    reset_n = 1'b0;
    logic [1:0]              endian_mode = 2'h3;
    logic                    four_byte_read_en = 1'b0;
    logic                    mem_io_sel = 1'b0;
    logic                    req_valid = 1'b0;
    tlelm_pkg::tlelm_req_s   req = '0;
    logic                    slow = 1'b0;
    logic                    req_ready, req_error, cfg_conflict, beat_valid, beat_ready;
    logic                    rbeat_valid, rdata_valid;
    tlelm_pkg::tlelm_beat_s  beat;
    tlelm_pkg::tlelm_rbeat_s rbeat;
    logic [63:0]             rdata;
    int                      bad_count = 0;
    int                      checked = 0;
    always #50 clock = ~clock;
    tlelm_lane_mapper dut (.clock, .reset_n, .endian_mode, .four_byte_read_en, .mem_io_sel,
        .req_valid, .req, .req_ready, .req_error, .cfg_conflict, .beat_valid, .beat,
        .beat_ready, .rbeat_valid, .rbeat, .rdata_valid, .rdata);
    tlelm_pci_model u_pci (.clock, .reset_n, .slow, .beat_valid, .beat, .beat_ready,
        .rbeat_valid, .rbeat);
    task print_verdict;
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [3:0] lane_mask(input int s, input int n, input int h);
        for (int k = 0; k < 4; k++) lane_mask[k] = (4*h+3-k >= s) && (4*h+3-k < s+n);
    endfunction : lane_mask
    function automatic logic [31:0] wide(input logic [3:0] m);
        for (int k = 0; k < 4; k++) wide[8*k+:8] = {8{m[k]}};
    endfunction : wide
    task automatic xfer(input logic [2:0] sz, input logic [2:0] st, input logic wr);
        logic [31:0] a, ea;
        logic [63:0] d, er, em;
        logic [3:0]  m;
        logic        ok;
        int          n, w;
        n = (sz == 3'h0) ? 8 : int'(sz);
        ok = st == 3'h0 || sz == 3'h1 || (sz == 3'h2 && !st[0]) || (sz == 3'h3 && !st[1])
            || (sz == 3'h4 && st == 3'h4) || (sz == 3'h5 && st == 3'h3)
            || (sz == 3'h6 && st == 3'h2) || (sz == 3'h7 && st == 3'h1);
        ok = ok && endian_mode == tlelm_pkg::END_TRUE_LE;
        a = 32'h1000_0040 | 32'(st);
        d = 64'h8192_a3b4_c5d6_e7f8;
        er = '0;
        em = '0;
        req <= '{a, sz, wr, d};
        req_valid <= 1'b1;
        w = 0;
        do begin @(negedge clock); w++; end while (req_ready !== 1'b1 && w < 20);
        req_valid <= 1'b0;
        chk("req_error", 64'(req_error), 64'(!ok));
        if (!ok) begin
            chk("no_beat", 64'(beat_valid), 64'h0);
            // let the refusal pulse end before the next request is raised
            @(negedge clock);
            chk("ready_pulse", 64'(req_ready), 64'h0);
        end
        for (int h = 0; h < 2 && ok; h++) begin
            m = lane_mask(st, n, h);
            if (m != 4'h0) begin
                w = 0;
                do begin @(negedge clock); w++; end while (!(beat_valid && beat_ready) && w < 20);
                ea = {a[31:3], h[0], 2'h0};
                chk("beat_addr", 64'(beat.addr), 64'(ea));
                chk("byte_en", 64'(beat.byte_en), 64'(m));
                chk("beat_data", 64'(beat.data & wide(m)), 64'(d[32*(1-h)+:32] & wide(m)));
                chk("beat_last", 64'(beat.last), 64'(h == 1 || lane_mask(st, n, 1) == 4'h0));
                er[32*(1-h)+:32] = ~ea & wide(m);
                em[32*(1-h)+:32] = wide(m);
            end
        end
        if (ok && !wr) begin
            w = 0;
            do begin @(negedge clock); w++; end while (rdata_valid !== 1'b1 && w < 20);
            chk("rdata", rdata & em, er);
        end
    endtask : xfer
    task automatic test_lane_table;
        for (int s = 0; s < 8; s++) for (int t = 0; t < 8; t++) for (int r = 0; r < 2; r++) begin
            slow = t[0] ^ r[0];
            xfer(s[2:0], t[2:0], r[0]);
        end
    endtask : test_lane_table
    task automatic test_mode_refused;
        for (int i = 0; i < 3; i++) begin
            endian_mode = i[1:0];
            xfer(3'h0, 3'h0, 1'b1);
        end
        endian_mode = 2'h3;
    endtask : test_mode_refused
    task automatic test_cfg_flag;
        for (int i = 0; i < 8; i++) begin
            endian_mode = {i[2], 1'b1};
            four_byte_read_en = i[1];
            mem_io_sel = i[0];
            repeat (2) @(negedge clock);
            chk("cfg_conflict", 64'(cfg_conflict), 64'(i[2] && i[1:0] != 2'h0));
        end
    endtask : test_cfg_flag
    initial begin
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        test_lane_table();
        test_mode_refused();
        test_cfg_flag();
        print_verdict();
    end
    initial begin
        #3_000_000;
        bad_count++;
        print_verdict();
    end
endmodule : tlelm_lane_mapper_tb_top
bind tlelm_lane_mapper tlelm_lane_mapper_asserts u_chk (.clock, .reset_n, .endian_mode,
    .four_byte_read_en, .mem_io_sel, .req_valid, .req_ready, .req_error, .cfg_conflict,
    .beat_valid, .beat, .beat_ready, .rbeat_valid, .rbeat, .rdata_valid);
